// ### verilog/aas_cfg.svh
// Register map, field positions and reset values of the averaging sequencer
`ifndef AAS_CFG_SVH
`define AAS_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define AAS_OFF_CTRL    8'h00
`define AAS_OFF_CFG     8'h04
`define AAS_OFF_STAT    8'h08
`define AAS_OFF_MASK    8'h0C
`define AAS_OFF_RESULT  8'h10
`define AAS_OFF_CHAN    8'h14

// ==========================================================================
// Control register bits
`define AAS_CTRL_EN     0
`define AAS_CTRL_START  1
`define AAS_CTRL_FREE   2
`define AAS_CTRL_SCAN   3
`define AAS_CTRL_UNS    4
`define AAS_CTRL_EVT    5

// ==========================================================================
// Configuration register fields (log2 of sample count, scan first/last)
`define AAS_CFG_AVG_LSB   0
`define AAS_CFG_FIRST_LSB 4
`define AAS_CFG_LAST_LSB  8

// ==========================================================================
// Status / mask bits
`define AAS_STAT_DONE   0
`define AAS_STAT_STOP   1
`define AAS_STAT_BUSY   8

// ==========================================================================
// Reset values
`define AAS_CTRL_RST    6'h00
`define AAS_CFG_RST     3'h0
`define AAS_MASK_RST    2'h0

`endif

// ### verilog/aas_pkg.sv
// Shared types of the averaging sequencer
package aas_pkg;

  // ========================================================================
  // Sequencer states
  typedef enum logic [1:0] {
    AAS_IDLE,
    AAS_REQ,
    AAS_WAIT,
    AAS_FIN
  } aas_state_e;

endpackage

// ### verilog/aas_accum.sv
// Sample accumulator with averaging shift
`timescale 1ns/1ps
module aas_accum #(
  parameter int DW     = 12,
  parameter int LOGN_W = 3
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // Control
  input  wire logic              i_clear,
  input  wire logic              i_add,
  input  wire logic              i_uns,
  input  wire logic [LOGN_W-1:0] i_shift,
  // Data
  input  wire logic [DW-1:0]     i_sample,
  output logic      [DW-1:0]     o_avg
);

  localparam int ACC_W = DW + (2**LOGN_W) - 1;

  typedef struct packed {
    logic [ACC_W-1:0] acc;
  } aas_accum_s;

  aas_accum_s s;
  aas_accum_s next_s;
  logic [ACC_W-1:0] ext;
  logic [ACC_W-1:0] shifted;

  // ========================================================================
  // Accumulate
  always_comb begin
    next_s = s;
    ext = i_uns ? {{(ACC_W-DW){1'b0}}, i_sample}
                : {{(ACC_W-DW){i_sample[DW-1]}}, i_sample};
    if (i_clear) begin
      next_s.acc = '0;
    end else if (i_add) begin
      next_s.acc = s.acc + ext;
    end
    // Unsigned sums shift in zeros, signed sums keep their sign
    if (i_uns) begin
      shifted = s.acc >> i_shift;
    end else begin
      shifted = $unsigned($signed(s.acc) >>> i_shift);
    end
    o_avg = shifted[DW-1:0];
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ========================================================================
  // Checks
  a_uns_zero_fill: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_uns && i_shift != '0) |-> !shifted[ACC_W-1])
    else $error("unsigned shift filled top bit with one");

endmodule

// ### verilog/aas_seq.sv
// Averaging sequencer: APB registers, trigger, scan and interrupt control
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`include "aas_cfg.svh"
module aas_seq #(
  parameter int DW     = 12,
  parameter int CH_W   = 4,
  parameter int LOGN_W = 3
) (
  // Clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  // APB slave
  input  wire logic            i_psel,
  input  wire logic            i_penable,
  input  wire logic            i_pwrite,
  input  wire logic [7:0]      i_paddr,
  input  wire logic [31:0]     i_pwdata,
  output logic      [31:0]     o_prdata,
  output logic                 o_pready,
  output logic                 o_pslverr,
  // Event trigger
  input  wire logic            i_event,
  // Sampling core
  output logic                 o_conv_req,
  output logic      [CH_W-1:0] o_conv_chan,
  input  wire logic            i_conv_done,
  input  wire logic [DW-1:0]   i_conv_data,
  // Interrupt
  output logic                 o_irq
);

  typedef struct packed {
    aas_pkg::aas_state_e fsm;
    logic                ctrl_en;
    logic                ctrl_free;
    logic                ctrl_scan;
    logic                ctrl_uns;
    logic                ctrl_evt;
    logic                start;
    logic                free_job;
    logic [LOGN_W-1:0]   cfg_avg;
    logic [CH_W-1:0]     cfg_first;
    logic [CH_W-1:0]     cfg_last;
    logic                stat_done;
    logic                stat_stop;
    logic [1:0]          mask;
    logic [7:0]          cnt;
    logic [CH_W-1:0]     chan;
    logic [DW-1:0]       result;
    logic [31:0]         prdata;
  } aas_seq_s;

  aas_seq_s        s;
  aas_seq_s        next_s;
  logic            acc_clear;
  logic            acc_add;
  logic [DW-1:0]   avg;
  logic            set_done;
  logic            set_stop;
  logic            setup;
  logic            wr;
  logic            wr_ctrl;
  logic            wr_cfg;
  logic            addr_ok;
  logic            trig;
  logic            abort_free;
  logic [7:0]      last_cnt;
  logic [CH_W-1:0] chan_step;

  // ========================================================================
  // Accumulator
  aas_accum #(
    .DW     (DW),
    .LOGN_W (LOGN_W)
  ) aas_accum_i (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_clear  (acc_clear),
    .i_add    (acc_add),
    .i_uns    (s.ctrl_uns),
    .i_shift  (s.cfg_avg),
    .i_sample (i_conv_data),
    .o_avg    (avg)
  );

  // ========================================================================
  // Bus decode
  always_comb begin
    setup   = i_psel & ~i_penable;
    wr      = i_psel & i_penable & i_pwrite;
    wr_ctrl = wr & (i_paddr == `AAS_OFF_CTRL);
    wr_cfg  = wr & (i_paddr == `AAS_OFF_CFG);
    unique case (i_paddr)
      `AAS_OFF_CTRL, `AAS_OFF_CFG, `AAS_OFF_STAT,
      `AAS_OFF_MASK, `AAS_OFF_RESULT, `AAS_OFF_CHAN: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign o_pready    = 1'b1;
  assign o_pslverr   = i_psel & i_penable & ~addr_ok;
  assign o_prdata    = s.prdata;
  assign o_conv_req  = (s.fsm == aas_pkg::AAS_REQ);
  assign o_conv_chan = s.chan;
  assign o_irq       = (s.stat_done & s.mask[0]) | (s.stat_stop & s.mask[1]);

  // ========================================================================
  // Sequencer
  always_comb begin
    next_s     = s;
    acc_clear  = 1'b0;
    acc_add    = 1'b0;
    set_done   = 1'b0;
    set_stop   = 1'b0;
    last_cnt   = (8'h01 << s.cfg_avg) - 8'h01;
    chan_step  = (s.chan == s.cfg_last) ? s.cfg_first : s.chan + {{(CH_W-1){1'b0}}, 1'b1};
    // Any one of these launches a whole average of N samples
    trig       = s.start | (s.ctrl_evt & i_event) | s.ctrl_free;
    abort_free = s.free_job & ~s.ctrl_free;

    if (!s.ctrl_en) begin
      // Disabling flushes partial samples left behind by a stop
      next_s.fsm      = aas_pkg::AAS_IDLE;
      next_s.cnt      = 8'h00;
      next_s.free_job = 1'b0;
      acc_clear       = 1'b1;
    end else if (s.fsm != aas_pkg::AAS_IDLE && abort_free) begin
      // Stop at once; the accumulator keeps what it has
      next_s.fsm      = aas_pkg::AAS_IDLE;
      next_s.cnt      = 8'h00;
      next_s.free_job = 1'b0;
      set_stop        = 1'b1;
    end else begin
      unique case (s.fsm)
        aas_pkg::AAS_IDLE: begin
          if (trig) begin
            next_s.fsm      = aas_pkg::AAS_REQ;
            next_s.start    = 1'b0;
            next_s.free_job = s.ctrl_free & ~s.start;
            next_s.cnt      = 8'h00;
            acc_clear       = 1'b1;
          end
        end
        aas_pkg::AAS_REQ: begin
          next_s.fsm = aas_pkg::AAS_WAIT;
        end
        aas_pkg::AAS_WAIT: begin
          if (i_conv_done) begin
            acc_add = 1'b1;
            if (s.cnt == last_cnt) begin
              next_s.fsm = aas_pkg::AAS_FIN;
            end else begin
              // Next sample needs no new trigger
              next_s.cnt = s.cnt + 8'h01;
              next_s.fsm = aas_pkg::AAS_REQ;
            end
          end
        end
        aas_pkg::AAS_FIN: begin
          next_s.result = avg;
          next_s.cnt    = 8'h00;
          set_done      = 1'b1;
          if (s.ctrl_scan) begin
            next_s.chan = chan_step;
          end
          // Free-run goes straight into the next average
          if (s.free_job) begin
            next_s.fsm = aas_pkg::AAS_REQ;
            acc_clear  = 1'b1;
          end else begin
            next_s.fsm = aas_pkg::AAS_IDLE;
          end
        end
      endcase
    end

    // Register writes
    if (wr_ctrl) begin
      next_s.ctrl_en   = i_pwdata[`AAS_CTRL_EN];
      next_s.ctrl_free = i_pwdata[`AAS_CTRL_FREE];
      next_s.ctrl_scan = i_pwdata[`AAS_CTRL_SCAN];
      next_s.ctrl_uns  = i_pwdata[`AAS_CTRL_UNS];
      next_s.ctrl_evt  = i_pwdata[`AAS_CTRL_EVT];
      if (i_pwdata[`AAS_CTRL_START]) begin
        next_s.start = 1'b1;
      end
    end
    if (wr_cfg) begin
      next_s.cfg_avg   = i_pwdata[`AAS_CFG_AVG_LSB +: LOGN_W];
      next_s.cfg_first = i_pwdata[`AAS_CFG_FIRST_LSB +: CH_W];
      next_s.cfg_last  = i_pwdata[`AAS_CFG_LAST_LSB +: CH_W];
      next_s.chan      = i_pwdata[`AAS_CFG_FIRST_LSB +: CH_W];
    end
    // Status bits clear on a written one
    if (wr && i_paddr == `AAS_OFF_STAT) begin
      next_s.stat_done = s.stat_done & ~i_pwdata[`AAS_STAT_DONE];
      next_s.stat_stop = s.stat_stop & ~i_pwdata[`AAS_STAT_STOP];
    end
    if (wr && i_paddr == `AAS_OFF_MASK) begin
      next_s.mask = {i_pwdata[`AAS_STAT_STOP], i_pwdata[`AAS_STAT_DONE]};
    end

    // Hardware set wins over a clear in the same cycle
    if (set_done) begin
      next_s.stat_done = 1'b1;
    end
    if (set_stop) begin
      next_s.stat_stop = 1'b1;
    end

    // Read data is captured in the setup cycle
    if (setup && !i_pwrite) begin
      unique case (i_paddr)
        `AAS_OFF_CTRL: begin
          next_s.prdata = 32'h0000_0000;
          next_s.prdata[`AAS_CTRL_EN]    = s.ctrl_en;
          next_s.prdata[`AAS_CTRL_START] = s.start;
          next_s.prdata[`AAS_CTRL_FREE]  = s.ctrl_free;
          next_s.prdata[`AAS_CTRL_SCAN]  = s.ctrl_scan;
          next_s.prdata[`AAS_CTRL_UNS]   = s.ctrl_uns;
          next_s.prdata[`AAS_CTRL_EVT]   = s.ctrl_evt;
        end
        `AAS_OFF_CFG: begin
          next_s.prdata = 32'h0000_0000;
          next_s.prdata[`AAS_CFG_AVG_LSB +: LOGN_W] = s.cfg_avg;
          next_s.prdata[`AAS_CFG_FIRST_LSB +: CH_W] = s.cfg_first;
          next_s.prdata[`AAS_CFG_LAST_LSB +: CH_W]  = s.cfg_last;
        end
        `AAS_OFF_STAT: begin
          next_s.prdata = 32'h0000_0000;
          next_s.prdata[`AAS_STAT_DONE] = s.stat_done;
          next_s.prdata[`AAS_STAT_STOP] = s.stat_stop;
          next_s.prdata[`AAS_STAT_BUSY] = (s.fsm != aas_pkg::AAS_IDLE);
        end
        `AAS_OFF_MASK: begin
          next_s.prdata = 32'h0000_0000;
          next_s.prdata[`AAS_STAT_DONE] = s.mask[0];
          next_s.prdata[`AAS_STAT_STOP] = s.mask[1];
        end
        `AAS_OFF_RESULT: begin
          next_s.prdata = {{(32-DW){1'b0}}, s.result};
        end
        `AAS_OFF_CHAN: begin
          next_s.prdata = {{(32-CH_W){1'b0}}, s.chan};
        end
        default: begin
          next_s.prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s           <= '0;
      s.fsm       <= aas_pkg::AAS_IDLE;
      // Reset values come from the configuration header
      s.ctrl_en   <= 1'(`AAS_CTRL_RST >> `AAS_CTRL_EN);
      s.cfg_avg   <= LOGN_W'(`AAS_CFG_RST);
      s.mask      <= `AAS_MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  // ========================================================================
  // Checks
  a_start_self_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    (s.fsm == aas_pkg::AAS_IDLE && s.start && s.ctrl_en && !wr_ctrl)
      |=> (!s.start && s.fsm == aas_pkg::AAS_REQ))
    else $error("start bit not cleared when taken");

  a_sample_no_trig: assert property (@(posedge i_clk) disable iff (i_rst)
    (s.fsm == aas_pkg::AAS_WAIT && i_conv_done && s.cnt != last_cnt
      && s.ctrl_en && !abort_free)
      |=> (s.fsm == aas_pkg::AAS_REQ && s.cnt == $past(s.cnt) + 8'h01))
    else $error("next sample not requested without trigger");

  a_event_launch: assert property (@(posedge i_clk) disable iff (i_rst)
    (s.fsm == aas_pkg::AAS_IDLE && s.ctrl_en && s.ctrl_evt && i_event)
      |=> s.fsm == aas_pkg::AAS_REQ ##1 s.fsm == aas_pkg::AAS_WAIT)
    else $error("event did not launch averaging");

  a_done_flag_set: assert property (@(posedge i_clk) disable iff (i_rst)
    (s.fsm == aas_pkg::AAS_FIN && s.ctrl_en && !abort_free)
      |=> (s.stat_done && s.result == $past(avg)))
    else $error("done flag or result missing after average");

  a_irq_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    (s.fsm == aas_pkg::AAS_FIN && s.ctrl_en && !abort_free && s.mask[0])
      |=> o_irq)
    else $error("interrupt not raised after final average");

  a_scan_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (s.fsm != aas_pkg::AAS_FIN && !wr_cfg) |=> $stable(s.chan))
    else $error("channel moved before average completed");

  a_scan_step: assert property (@(posedge i_clk) disable iff (i_rst)
    (s.fsm == aas_pkg::AAS_FIN && s.ctrl_en && s.ctrl_scan && !abort_free
      && !wr_cfg && s.chan != s.cfg_last)
      |=> s.chan == CH_W'($past(s.chan) + 1'b1))
    else $error("channel did not advance after average");

  a_free_stop: assert property (@(posedge i_clk) disable iff (i_rst)
    (s.fsm != aas_pkg::AAS_IDLE && s.ctrl_en && abort_free)
      |=> (s.fsm == aas_pkg::AAS_IDLE && s.stat_stop) [*2])
    else $error("free-run averaging not stopped at once");

  // Further pacing, hold and flush checks
  a_req_one_cycle: assert property (@(posedge i_clk) disable iff (i_rst)
    o_conv_req |=> !o_conv_req)
    else $error("conversion request held for more than one cycle");

  a_busy_no_retrig: assert property (@(posedge i_clk) disable iff (i_rst)
    (s.fsm == aas_pkg::AAS_WAIT && s.ctrl_en && !abort_free && !i_conv_done)
      |=> s.fsm == aas_pkg::AAS_WAIT)
    else $error("sample wait left without an answer");

  a_result_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (s.fsm != aas_pkg::AAS_FIN) |=> $stable(s.result))
    else $error("result changed before average completed");

  a_scan_off_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (s.fsm == aas_pkg::AAS_FIN && !s.ctrl_scan && !wr_cfg)
      |=> $stable(s.chan))
    else $error("channel moved with scan disabled");

  a_stop_keeps_acc: assert property (@(posedge i_clk) disable iff (i_rst)
    (s.fsm != aas_pkg::AAS_IDLE && s.ctrl_en && abort_free) |-> !acc_clear)
    else $error("free-run stop flushed the accumulator");

endmodule

// ### tb/aas_core_model.sv
// Behavioural model of the sampling core answering conversion requests
`timescale 1ns/1ps
module aas_core_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Requests from the sequencer
  input  wire logic        i_req,
  input  wire logic [3:0]  i_chan,
  // Bench controls
  input  wire logic [3:0]  i_delay,
  input  wire logic [11:0] i_base,
  // Answers
  output logic             o_done,
  output logic [11:0]      o_data
);
  logic odd;

  initial begin
    o_done = 1'b0;
    o_data = 12'hA5A;
    odd    = 1'b0;
  end

  // ==========
  // Sample is base plus 16 per channel, plus 2 on every second answer
  always begin
    @(posedge i_clk);
    if (i_rst) begin
      odd = 1'b0;
    end else if (i_req) begin
      repeat (i_delay) @(posedge i_clk);
      o_done <= 1'b1;
      o_data <= i_base + {4'h0, i_chan, 4'h0} + {10'h000, odd, 1'b0};
      odd = !odd;
      @(posedge i_clk);
      o_done <= 1'b0;
      o_data <= ~o_data;
    end
  end
endmodule

// ### tb/adc_averaging_sequencer_tb.sv
// Self-checking bench of the averaging sequencer
`timescale 1ns/1ps
`include "aas_cfg.svh"
module adc_averaging_sequencer_tb;
  typedef struct packed {
    logic [2:0]  avg;
    logic [3:0]  dly;
    logic [11:0] base;
    logic        uns;
    logic        evt;
    logic        msk;
    logic [11:0] res;
  } aas_row_s;

  logic        clk, rst, psel, penable, pwrite, pready, err, evt;
  logic        conv_req, conv_done, irq, err_seen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, ctl;
  logic [3:0]  conv_chan, dly;
  logic [11:0] conv_data, base;
  int          miscompares, checks_done, reqs, r0, n;
  aas_row_s    rows [4];

  aas_seq aas_seq_i (
    .i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(err), .i_event(evt), .o_conv_req(conv_req),
    .o_conv_chan(conv_chan), .i_conv_done(conv_done), .i_conv_data(conv_data),
    .o_irq(irq)
  );

  aas_core_model aas_core_model_i (
    .i_clk(clk), .i_rst(rst), .i_req(conv_req), .i_chan(conv_chan),
    .i_delay(dly), .i_base(base), .o_done(conv_done), .o_data(conv_data)
  );

  // ==========
  // Clock, request counter and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (conv_req === 1'b1) begin
      reqs++;
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  // ==========
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      complete_run();
    end
    rd       = prdata;
    err_seen = err;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_done();
    int k;
    k = 0;
    do begin
      apb(`AAS_OFF_STAT, 1'b0, 32'h0);
      k++;
    end while (rd[`AAS_STAT_DONE] !== 1'b1 && k < 500);
    check({31'h0, rd[`AAS_STAT_DONE]}, 32'h1);
    if (rd[`AAS_STAT_DONE] !== 1'b1) begin
      complete_run();
    end
  endtask

  // ==========
  // Main sequence
  initial begin
    {rst, psel, penable, pwrite, evt} = 5'h10;
    {paddr, pwdata, dly, base} = '0;
    {miscompares, checks_done, reqs} = '0;
    rows[0] = '{3'd1, 4'd0, 12'h100, 1'b1, 1'b0, 1'b1, 12'h101};
    rows[1] = '{3'd2, 4'd3, 12'hF00, 1'b1, 1'b0, 1'b1, 12'hF01};
    rows[2] = '{3'd3, 4'd1, 12'h7F0, 1'b0, 1'b1, 1'b1, 12'h7F1};
    rows[3] = '{3'd1, 4'd5, 12'hF00, 1'b0, 1'b0, 1'b0, 12'hF01};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[k]) begin
      dly  <= rows[k].dly;
      base <= rows[k].base;
      apb(`AAS_OFF_MASK, 1'b1, {31'h0, rows[k].msk});
      apb(`AAS_OFF_CFG, 1'b1, {29'h0, rows[k].avg});
      ctl = 32'h0;
      ctl[`AAS_CTRL_EN]  = 1'b1;
      ctl[`AAS_CTRL_UNS] = rows[k].uns;
      ctl[rows[k].evt ? `AAS_CTRL_EVT : `AAS_CTRL_START] = 1'b1;
      r0 = reqs;
      apb(`AAS_OFF_CTRL, 1'b1, ctl);
      if (rows[k].evt) begin
        evt <= 1'b1;
        @(posedge clk);
        evt <= 1'b0;
      end
      wait_done();
      check(reqs - r0, 32'h1 << rows[k].avg);
      check({31'h0, irq}, {31'h0, rows[k].msk});
      apb(`AAS_OFF_RESULT, 1'b0, 32'h0);
      check(rd, {20'h0, rows[k].res});
      apb(`AAS_OFF_CTRL, 1'b0, 32'h0);
      check({31'h0, rd[`AAS_CTRL_START]}, 32'h0);
      apb(`AAS_OFF_STAT, 1'b1, 32'h1);
      check({31'h0, irq}, 32'h0);
      $display("Row %0d finished", k);
    end

    // Second reset: every register back to zero, unmapped access refused
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 24; a += 4) begin
      apb(a[7:0], 1'b0, 32'h0);
      check(rd, 32'h0);
    end
    apb(8'h40, 1'b0, 32'h0);
    check({31'h0, err_seen}, 32'h1);
    check(rd, 32'h0);
    $display("Reset and unmapped test finished");

    // Scan over channels 2 and 3 advances once per full average
    dly  <= 4'd2;
    base <= 12'h300;
    apb(`AAS_OFF_CFG, 1'b1, 32'h321);
    for (int j = 0; j < 2; j++) begin
      r0 = reqs;
      apb(`AAS_OFF_CTRL, 1'b1, 32'h0B);
      wait_done();
      check(reqs - r0, 32'h2);
      apb(`AAS_OFF_RESULT, 1'b0, 32'h0);
      check(rd, 32'h321 + 32'h10 * j);
      apb(`AAS_OFF_CHAN, 1'b0, 32'h0);
      check(rd, (j == 0) ? 32'h3 : 32'h2);
      apb(`AAS_OFF_STAT, 1'b1, 32'h1);
    end
    $display("Scan test finished");

    // Free-run cleared mid-average stops at once; disable flushes partials
    dly  <= 4'd8;
    base <= 12'h200;
    apb(`AAS_OFF_CFG, 1'b1, 32'h003);
    apb(`AAS_OFF_MASK, 1'b1, 32'h2);
    r0 = reqs;
    apb(`AAS_OFF_CTRL, 1'b1, 32'h05);
    n = 0;
    while (reqs - r0 < 3 && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (reqs - r0 < 3) begin
      miscompares++;
      complete_run();
    end
    apb(`AAS_OFF_CTRL, 1'b1, 32'h01);
    repeat (2) @(posedge clk);
    r0 = reqs;
    apb(`AAS_OFF_STAT, 1'b0, 32'h0);
    check(rd & 32'h103, 32'h002);
    check({31'h0, irq}, 32'h1);
    repeat (20) @(posedge clk);
    check(reqs - r0, 32'h0);
    apb(`AAS_OFF_CTRL, 1'b1, 32'h00);
    apb(`AAS_OFF_CTRL, 1'b1, 32'h01);
    apb(`AAS_OFF_STAT, 1'b1, 32'h3);
    apb(`AAS_OFF_CFG, 1'b1, 32'h001);
    apb(`AAS_OFF_CTRL, 1'b1, 32'h03);
    wait_done();
    apb(`AAS_OFF_RESULT, 1'b0, 32'h0);
    check(rd, 32'h201);
    $display("Free-run stop test finished");
    complete_run();
  end
endmodule
